// File: bench/osm_host_model.sv
// host microcontroller model: spi mode writes and soft reset requests
// assumes clk is shared with the device and tasks are called by the bench
`timescale 1ns/100ps
`default_nettype none
module osm_host_model (
	input wire logic clk,
	output logic mode_wr,
	output logic [2:0] mode_wdata,
	output logic soft_reset
);
	initial begin
		mode_wr = 1'b0;
		mode_wdata = 3'h0;
		soft_reset = 1'b0;
	end
	task automatic send(input logic [2:0] code);
		@(posedge clk);
		mode_wr <= 1'b1;
		mode_wdata <= code;
		@(posedge clk);
		mode_wr <= 1'b0;
		// released data must not keep showing the last code
		mode_wdata <= ~code;
	endtask
	task automatic reboot();
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the operating mode state machine
// assumes short reset delays of 4 and 2 cycles at the design instance
`timescale 1ns/100ps
`default_nettype none
module tb;
	import osm_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
	int errors = 0;
	int checked = 0;
	logic clk, resetn, rd_sel_second, wd_fail, crit_fail, main_regulator_output_uv;
	logic overtemp, can_wake, hv_wake, gpio_wake, test_pin, cfg_pin;
	logic mode_wr, soft_reset;
	logic [2:0] mode_wdata, mode_field;
	osm_state_e state;
	logic main_reg, sec_reg, rst_n, dev_mode, wd_halt, wd_long;
	logic can_norm, cfg_fs;
	osm_top #(.RD_FIRST_CYC(4), .RD_SECOND_CYC(2)) u_osm_top (.clk(clk),
		.resetn(resetn), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
		.soft_reset(soft_reset), .rd_sel_second(rd_sel_second),
		.wd_fail(wd_fail), .crit_fail(crit_fail), .main_regulator_output_uv(main_regulator_output_uv),
		.overtemp(overtemp), .can_wake(can_wake),
		.high_voltage_wake_input(hv_wake), .gpio_wake(gpio_wake),
		.test_pin(test_pin), .cfg_pin(cfg_pin), .state(state),
		.mode_field(mode_field), .main_regulator_output(main_reg),
		.secondary_regulator_output(sec_reg),
		.host_reset_output_n(rst_n), .dev_mode(dev_mode),
		.wd_halt(wd_halt), .wd_long_window(wd_long),
		.can_force_normal(can_norm), .cfg_failsafe(cfg_fs));
	osm_host_model u_osm_host_model (.clk(clk), .mode_wr(mode_wr),
		.mode_wdata(mode_wdata), .soft_reset(soft_reset));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_st(input osm_state_e s, input int n);
		int i;
		@(negedge clk);
		for (i = 0; i < n && state !== s; i++)
			@(negedge clk);
		`CHK(state, s)
		if (state !== s)
			close_out();
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_init();
		cyc(3);
		`CHK(state, OSM_INIT)
		`CHK(rst_n, 1'b1)
		`CHK(wd_long, 1'b1)
	endtask
	task automatic t_sleep_wake();
		u_osm_host_model.send(3'h2);
		wait_st(OSM_STOP, 4);
		cyc(2);
		`CHK(main_reg, 1'b1)
		`CHK(mode_field, 3'h2)
		u_osm_host_model.send(3'h1);
		wait_st(OSM_SLEEP, 4);
		cyc(2);
		`CHK(main_reg, 1'b0)
		u_osm_host_model.send(3'h0);
		cyc(3);
		`CHK(state, OSM_SLEEP)
		@(posedge clk);
		can_wake <= 1'b1;
		main_regulator_output_uv <= 1'b1;
		wait_st(OSM_RESTART, 6);
		cyc(8);
		`CHK(state, OSM_RESTART)
		`CHK(rst_n, 1'b0)
		`CHK(mode_field, 3'h0)
		@(posedge clk);
		can_wake <= 1'b0;
		main_regulator_output_uv <= 1'b0;
		wait_st(OSM_NORMAL, 8);
		cyc(2);
		`CHK(rst_n, 1'b1)
	endtask
	task automatic t_fault();
		@(posedge clk);
		rd_sel_second <= 1'b1;
		u_osm_host_model.send(3'h5);
		cyc(3);
		`CHK(state, OSM_NORMAL)
		`CHK(mode_field, 3'h0)
		@(posedge clk);
		main_regulator_output_uv <= 1'b1;
		@(posedge clk);
		main_regulator_output_uv <= 1'b0;
		wait_st(OSM_RESTART, 4);
		cyc(1);
		`CHK(state, OSM_RESTART)
		cyc(1);
		`CHK(state, OSM_NORMAL)
	endtask
	// strap high at power-up restarts; a second power-up with it low escalates
	task automatic t_watchdog();
		`CHK(cfg_fs, 1'b0)
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		wait_st(OSM_RESTART, 4);
		wait_st(OSM_NORMAL, 6);
		@(posedge clk);
		resetn <= 1'b0;
		cfg_pin <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		cyc(4);
		`CHK(state, OSM_INIT)
		`CHK(cfg_fs, 1'b1)
		`CHK(wd_long, 1'b1)
		u_osm_host_model.send(3'h0);
		wait_st(OSM_NORMAL, 4);
		@(posedge clk);
		wd_fail <= 1'b1;
		@(posedge clk);
		wd_fail <= 1'b0;
		wait_st(OSM_FAILSAFE, 4);
		wait_st(OSM_NORMAL, 8);
	endtask
	// exit causes: 0 overtemperature gone, 1 gpio wake, 2 high-voltage wake
	task automatic t_failsafe(input int w);
		@(posedge clk);
		overtemp <= 1'b1;
		crit_fail <= 1'b1;
		wait_st(OSM_FAILSAFE, 4);
		@(posedge clk);
		crit_fail <= 1'b0;
		cyc(10);
		`CHK(main_reg, 1'b0)
		`CHK(state, OSM_FAILSAFE)
		u_osm_host_model.send(3'h0);
		cyc(3);
		`CHK(state, OSM_FAILSAFE)
		@(posedge clk);
		overtemp <= (w != 0);
		gpio_wake <= (w == 1);
		hv_wake <= (w == 2);
		wait_st(OSM_RESTART, 6);
		@(posedge clk);
		{overtemp, gpio_wake, hv_wake} <= 3'h0;
		wait_st(OSM_NORMAL, 10);
	endtask
	task automatic t_dev();
		@(posedge clk);
		test_pin <= 1'b1;
		u_osm_host_model.reboot();
		wait_st(OSM_INIT, 4);
		cyc(4);
		`CHK(dev_mode, 1'b1)
		`CHK(wd_halt, 1'b1)
		`CHK(can_norm, 1'b1)
		`CHK(sec_reg, 1'b1)
		u_osm_host_model.send(3'h2);
		wait_st(OSM_STOP, 4);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		{rd_sel_second, wd_fail, crit_fail, main_regulator_output_uv, overtemp} = 5'h00;
		{can_wake, hv_wake, gpio_wake, test_pin} = 4'h0;
		cfg_pin = 1'b1;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_init();
		t_sleep_wake();
		t_fault();
		for (int w = 0; w < 3; w++)
			t_failsafe(w);
		t_watchdog();
		t_dev();
		close_out();
	end
endmodule
`default_nettype wire

// File: rtl/osm_map.svh
// constants of the operating mode state machine
// assumes inclusion by the design files only
`ifndef OSM_MAP_SVH
`define OSM_MAP_SVH
`define OSM_MODE_NORMAL 3'h0
`define OSM_MODE_SLEEP 3'h1
`define OSM_MODE_STOP 3'h2
`define OSM_MODE_RESET 3'h3
`define OSM_FRAME_BITS 16
`define OSM_RD_FIRST_NS 10000000
`define OSM_RD_SECOND_NS 1000000
`define OSM_CLK_NS 100
`define OSM_SYNC_STAGES 2
`endif

// File: rtl/osm_pkg.sv
// types of the operating mode state machine
// assumes nothing of its surroundings
package osm_pkg;
	typedef enum logic [2:0] {
		OSM_INIT,
		OSM_NORMAL,
		OSM_STOP,
		OSM_SLEEP,
		OSM_RESTART,
		OSM_FAILSAFE
	} osm_state_e;
	typedef logic [2:0] osm_mode_t;
endpackage

// File: rtl/osm_sync.sv
// two-flop synchroniser for a bus of pin levels
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module osm_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: rtl/osm_top.sv
// operating mode state machine of a system basis chip
// assumes mode requests from an spi decoder on clk, events from pins
`timescale 1ns/100ps
`default_nettype none
`include "osm_map.svh"
module osm_top #(
	parameter int RD_FIRST_CYC = `OSM_RD_FIRST_NS / `OSM_CLK_NS,
	parameter int RD_SECOND_CYC = `OSM_RD_SECOND_NS / `OSM_CLK_NS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic mode_wr,
	input wire logic [2:0] mode_wdata,
	input wire logic soft_reset,
	input wire logic rd_sel_second,
	input wire logic wd_fail,
	input wire logic crit_fail,
	input wire logic main_regulator_output_uv,
	input wire logic overtemp,
	input wire logic can_wake,
	input wire logic high_voltage_wake_input,
	input wire logic gpio_wake,
	input wire logic test_pin,
	input wire logic cfg_pin,
	output osm_pkg::osm_state_e state,
	output logic [2:0] mode_field,
	output logic main_regulator_output,
	output logic secondary_regulator_output,
	output logic host_reset_output_n,
	output logic dev_mode,
	output logic wd_halt,
	output logic wd_long_window,
	output logic can_force_normal,
	output logic cfg_failsafe
);
	import osm_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [4:0] pins_s;
	logic test_s, cfg_s, can_w, hv_w, gp_w;
	logic wake;
	logic [31:0] rd_cnt_q;
	logic wd_fail_seen_q;
	logic rst_rel_q;
	logic [1:0] sync_age_q;

	osm_sync #(.W(5)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in({test_pin, cfg_pin, can_wake, high_voltage_wake_input,
			gpio_wake}),
		.sync_out(pins_s)
	);
	assign {test_s, cfg_s, can_w, hv_w, gp_w} = pins_s;
	assign wake = can_w | hv_w | gp_w;

	function automatic logic [31:0] delay_of(input logic sel);
		delay_of = sel ? 32'(RD_SECOND_CYC) : 32'(RD_FIRST_CYC);
	endfunction

	////////////////////////////////////////////////////////////////////
	// watchdog failure: fail-safe config escalates, other config restarts
	logic to_failsafe, to_restart, mode_take;
	always_comb begin
		to_failsafe = crit_fail | (wd_fail & cfg_failsafe);
		to_restart = main_regulator_output_uv | (wd_fail & !cfg_failsafe);
		// illegal codes and writes outside spi-reachable modes are dropped
		mode_take = mode_wr && !to_failsafe && !to_restart &&
			mode_wdata <= `OSM_MODE_RESET &&
			state inside {OSM_INIT, OSM_NORMAL, OSM_STOP};
	end

	always_ff @(posedge clk) begin
		if (!resetn || soft_reset) begin
			state <= OSM_INIT;
		end else begin
			unique case (state)
			OSM_INIT, OSM_NORMAL, OSM_STOP: begin
				if (to_failsafe)
					state <= OSM_FAILSAFE;
				else if (to_restart)
					state <= OSM_RESTART;
				else if (mode_wr) begin
					// only these modes are spi reachable
					unique case (mode_wdata)
					`OSM_MODE_NORMAL: state <= OSM_NORMAL;
					`OSM_MODE_STOP: state <= OSM_STOP;
					`OSM_MODE_SLEEP: state <= OSM_SLEEP;
					`OSM_MODE_RESET: state <= OSM_RESTART;
					default: state <= state;
					endcase
				end
			end
			OSM_SLEEP: begin
				if (crit_fail)
					state <= OSM_FAILSAFE;
				else if (wake)
					state <= OSM_RESTART;
			end
			OSM_RESTART: begin
				if (to_failsafe)
					state <= OSM_FAILSAFE;
				else if (!to_restart && rd_cnt_q == 32'h0)
					state <= OSM_NORMAL;
			end
			OSM_FAILSAFE: begin
				if (wake || !overtemp)
					state <= OSM_RESTART;
			end
			endcase
		end
	end

	// delay counter reloads while a fault still holds the reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_cnt_q <= 32'h0;
		end else if (state != OSM_RESTART || to_restart) begin
			rd_cnt_q <= delay_of(rd_sel_second) - 32'h1;
		end else if (rd_cnt_q != 32'h0) begin
			rd_cnt_q <= rd_cnt_q - 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode field cleared on restart so a read returns the live mode
	always_ff @(posedge clk) begin
		if (!resetn || state == OSM_RESTART) begin
			mode_field <= `OSM_MODE_NORMAL;
		end else if (mode_take) begin
			mode_field <= mode_wdata;
		end
	end

	// reset output low in restart, fail-safe and sleep, and while resetn is low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			host_reset_output_n <= 1'b0;
			rst_rel_q <= 1'b0;
		end else begin
			host_reset_output_n <= !(state == OSM_RESTART ||
				state == OSM_FAILSAFE || state == OSM_SLEEP);
			rst_rel_q <= host_reset_output_n;
		end
	end

	// synchroniser shows real pin levels only two edges after reset release
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync_age_q <= 2'h0;
		end else if (sync_age_q != 2'h3) begin
			sync_age_q <= sync_age_q + 2'h1;
		end
	end

	// strap levels taken while in init, held afterwards
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dev_mode <= 1'b0;
			cfg_failsafe <= 1'b1;
		end else if (state == OSM_INIT) begin
			dev_mode <= test_s;
			// retaken once flushed, else the strap would never count
			if (!host_reset_output_n || sync_age_q == 2'h2)
				cfg_failsafe <= !cfg_s;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			main_regulator_output <= 1'b0;
			secondary_regulator_output <= 1'b0;
			can_force_normal <= 1'b0;
			wd_halt <= 1'b0;
		end else begin
			main_regulator_output <= !(state == OSM_SLEEP ||
				state == OSM_FAILSAFE);
			secondary_regulator_output <= dev_mode;
			can_force_normal <= dev_mode;
			wd_halt <= dev_mode;
		end
	end

	// long window from a release edge in init until first spi mode write or leaving init
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wd_long_window <= 1'b0;
			wd_fail_seen_q <= 1'b0;
		end else begin
			wd_fail_seen_q <= wd_fail;
			if (host_reset_output_n && !rst_rel_q && state == OSM_INIT)
				wd_long_window <= 1'b1;
			else if (mode_wr || state != OSM_INIT)
				wd_long_window <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	chk_sleep_reg_off: assert property (@(posedge clk) disable iff (!resetn)
		state == OSM_SLEEP |=> !main_regulator_output)
		else $error("regulator on in sleep");
	chk_stop_reg_on: assert property (@(posedge clk) disable iff (!resetn)
		state == OSM_STOP |=> main_regulator_output)
		else $error("regulator off in stop");
	chk_fs_reg_off: assert property (@(posedge clk) disable iff (!resetn)
		state == OSM_FAILSAFE |=> !main_regulator_output)
		else $error("regulator on in fail-safe");
	chk_soft_init: assert property (@(posedge clk) disable iff (!resetn)
		soft_reset |=> state == OSM_INIT)
		else $error("soft reset missed init");
	chk_wake_restart: assert property (@(posedge clk)
		disable iff (!resetn || soft_reset)
		state == OSM_SLEEP && wake && !crit_fail |=> state == OSM_RESTART)
		else $error("wake did not restart");
	chk_fs_hold: assert property (@(posedge clk)
		disable iff (!resetn || soft_reset)
		state == OSM_FAILSAFE && !wake && overtemp |=> state == OSM_FAILSAFE)
		else $error("left fail-safe without cause");
	chk_restart_clr: assert property (@(posedge clk) disable iff (!resetn)
		state == OSM_RESTART |=> mode_field == `OSM_MODE_NORMAL)
		else $error("mode field not cleared");
	chk_dev_outs: assert property (@(posedge clk) disable iff (!resetn)
		dev_mode |=> wd_halt && can_force_normal
		&& secondary_regulator_output)
		else $error("development outputs wrong");
	chk_wd_cfg: assert property (@(posedge clk)
		disable iff (!resetn || soft_reset)
		state == OSM_NORMAL && wd_fail && !crit_fail
		|=> state == (cfg_failsafe ? OSM_FAILSAFE : OSM_RESTART))
		else $error("watchdog reaction wrong");
	chk_rd_exit: assert property (@(posedge clk)
		disable iff (!resetn || soft_reset)
		$fell(state == OSM_RESTART) |-> state inside {OSM_NORMAL, OSM_FAILSAFE})
		else $error("restart left to wrong mode");
	chk_bad_req: assert property (@(posedge clk)
		disable iff (!resetn || soft_reset)
		state == OSM_NORMAL && mode_wr && mode_wdata > `OSM_MODE_RESET
		&& !to_failsafe && !to_restart |=> state == OSM_NORMAL)
		else $error("illegal request acted on");

	cov_sleep: cover property (@(posedge clk) state == OSM_SLEEP);
	cov_rd_done: cover property (@(posedge clk)
		state == OSM_RESTART ##1 state == OSM_NORMAL);
	cov_fs_exit: cover property (@(posedge clk)
		state == OSM_FAILSAFE ##1 state == OSM_RESTART);
	cov_dev: cover property (@(posedge clk) dev_mode);
endmodule
`default_nettype wire
